// ---- design/sts_crc.sv ----
// Purpose: Serial checksum over a parameter byte stream.
// Assumes: Bytes arrive one per strobe, last byte flagged.
// Notes:   Result holds until the next stream starts.
`default_nettype none
module sts_crc #(
	parameter logic [31:0] POLY = sts_pkg::CRC_POLY
) (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        byte_valid_i,
	input  wire logic [7:0]  byte_i,
	input  wire logic        last_i,
	input  wire logic [31:0] expect_i,
	output logic             done_o,
	output logic             ok_o
);
	import sts_pkg::*;
	logic [31:0] crc; // Running remainder.

	// Folds one byte into the remainder, msb first.
	function automatic logic [31:0] step(input logic [31:0] c, input logic [7:0] b);
		logic [31:0] r;
		r = c ^ {b, 24'h0};
		for (int i = 0; i < 8; i++) begin
			r = r[31] ? ((r << 1) ^ POLY) : (r << 1);
		end
		return r;
	endfunction : step

	wire [31:0] next_crc = step(crc, byte_i);

	////////////////////////////////////////////////////////////////
	// A new stream clears the result; the last byte makes the verdict.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			crc    <= 32'h0;
			done_o <= 1'b0;
			ok_o   <= 1'b0;
		end else if (byte_valid_i) begin
			crc    <= last_i ? 32'h0 : next_crc;
			done_o <= last_i;
			ok_o   <= last_i && (next_crc == expect_i);
		end
	end
endmodule : sts_crc
`default_nettype wire

// ---- design/sts_trailer.sv ----
// Purpose: Safe control/status byte handling, passivation and checks.
// Assumes: Telegram and fault inputs are on the processing clock.
// Notes:   Status byte bits are flip-flops except bit 7, tied low; bit 1 is picked by variant.
`default_nettype none
// Notes on behaviour
// RULE1: Bit 0 flags applied new parameters.
// RULE2: Basic variant: bit 1 is device fault.
// RULE3: Expanded: bit 1 is pending channel error.
// RULE4: Bit 2 flags telegram checksum error.
// RULE5: Watchdog expiry passivates, sets bit 3.
// RULE6: Passivated outputs zeros, sets bit 4.
// RULE7: Passivate at start-up, errors, faults.
// RULE8: Bit 6 flags counter reset; bit 7 zero.
// RULE9: Control bit 1 acknowledges re-integration.
// RULE10: Control bit 2 resets sequence counter.
// RULE11: Expanded: control bit 3 selects second watchdog.
// RULE12: Control bit 4 forces substitute values.
// RULE13: Expanded: control bit 6 clears channel error.
// RULE14: Host drives bit 7 high in expanded.
// RULE15: Checksum length three or four bytes.
// RULE16: Seed parameters present select expanded variant.
// RULE17: Parameter checksum option is never evaluated.
// RULE18: Requested safety class must be supported.
// RULE19: Destination matches stored address, differs source.
// RULE20: Device parameter checksum is verified.
// RULE21: Safety parameter checksum is verified.
// RULE22: Host picks a sensible watchdog time.
// RULE23: Bit 0 edges unlock and clear status.
// RULE24: Control toggle mirrors into status toggle.
module sts_trailer #(
	parameter int          CYCLES_PER_MS = sts_pkg::CYC_PER_MS,
	parameter logic [15:0] DEV_ADDR      = sts_pkg::DEV_ADDR_DEF,
	parameter int          DATA_W        = 32
) (
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	input  wire sts_pkg::sts_tlg_t tlg_i,
	input  wire sts_pkg::sts_fpar_t fpar_i,
	input  wire logic              par_valid_i,
	input  wire logic [7:0]        par_byte_i,
	input  wire logic              par_last_i,
	input  wire logic              par_is_fpar_i,
	input  wire logic              param_applied_i,
	input  wire logic              device_fault_i,
	input  wire logic              channel_error_i,
	input  wire logic              window_exceeded_i,
	input  wire logic              internal_tlg_fault_i,
	input  wire logic [DATA_W-1:0] cyc_data_i,
	output logic [DATA_W-1:0]      data_o,
	output logic [7:0]             safety_status_byte_o,
	output logic                   param_write_ready_o,
	output logic                   expanded_variant_o,
	output logic [2:0]             crc_len_o,
	output logic [15:0]            seq_count_o
);
	import sts_pkg::*;

	////////////////////////////////////////////////////////////////
	// Declarations.
	typedef enum logic [1:0] {S_START, S_RUN, S_PASSIVE} sts_state_t;
	sts_state_t  state;                    // Passivation state.
	sts_state_t  next_state;               // Its next value.
	logic [7:0]  safety_control_byte;      // Last accepted control byte.
	logic [7:0]  ctrl_prev;                // Control byte one cycle ago.
	logic        param_set_applied;        // Status bit 0 flag.
	logic        device_fault_q;           // Registered fault level.
	logic        channel_error_ack_needed; // Pending channel error.
	logic        crc_err;                  // Sticky checksum error.
	logic        telegram_watchdog_expired; // Sticky watchdog flag.
	logic        seq_counter_was_reset;    // Status bit 6 flag.
	logic        substitute_values_active; // Status bit 4 flag.
	logic        wd_fire;                  // Watchdog level.
	logic        devpar_done, devpar_ok;   // Device parameter checksum.
	logic        fpar_done, fpar_ok;       // Safety parameter checksum.

	// Edge finders on the held control byte.
	function automatic logic rose(input logic [7:0] n, input logic [7:0] p, input int b);
		return n[b] & ~p[b];
	endfunction : rose
	function automatic logic fell(input logic [7:0] n, input logic [7:0] p, input int b);
		return ~n[b] & p[b];
	endfunction : fell

	////////////////////////////////////////////////////////////////
	// Decoding.
	wire expanded_variant = fpar_i.has_seed_passiv;         // RULE16
	wire basic_variant    = ~expanded_variant;
	wire good_tlg    = tlg_i.valid & tlg_i.crc_ok & tlg_i.current;
	wire crc_err_evt = tlg_i.valid & ~tlg_i.crc_ok;          // RULE4
	wire unlock_rise = rose(safety_control_byte, ctrl_prev, CT_UNLOCK);
	wire unlock_fall = fell(safety_control_byte, ctrl_prev, CT_UNLOCK);
	wire opack_rise  = rose(safety_control_byte, ctrl_prev, CT_OPACK);
	wire seqrst_rise = rose(safety_control_byte, ctrl_prev, CT_SEQRST);
	wire seqrst_fall = fell(safety_control_byte, ctrl_prev, CT_SEQRST);
	// The acknowledge bit is reserved in the basic variant.
	wire chack_rise  = expanded_variant
		& rose(safety_control_byte, ctrl_prev, CT_CHACK);    // RULE13
	wire force_subst = safety_control_byte[CT_FORCE];        // RULE12
	// Second watchdog time only counts in the expanded variant.
	wire use_wd2     = expanded_variant & safety_control_byte[CT_WD2]; // RULE11
	wire [15:0] wd_period = use_wd2 ? fpar_i.second_watchdog_period
		: fpar_i.watchdog_period;
	// The check option is fixed to no-check, so it is never read here.
	wire addr_ok  = (fpar_i.dest_addr == DEV_ADDR)
		& (fpar_i.src_addr != fpar_i.dest_addr);             // RULE19
	wire sil_ok   = (fpar_i.requested_safety_class <= SIL_MAX); // RULE18
	wire crcs_ok  = devpar_done & devpar_ok & fpar_done & fpar_ok; // RULE20 RULE21
	wire param_ok = addr_ok & sil_ok & crcs_ok; // RULE17
	// Every fault that must drop the channel into substitute values, except the channel error.
	wire fault_evt = crc_err_evt | wd_fire | window_exceeded_i
		| internal_tlg_fault_i | device_fault_i | ~param_ok; // RULE7
	wire passivated = (state != S_RUN) | force_subst
		| channel_error_ack_needed;                          // RULE6 RULE3
	wire reintegrate = (state == S_PASSIVE) & (next_state == S_RUN);

	assign expanded_variant_o = expanded_variant;
	assign crc_len_o = expanded_variant ? CRC_LEN_EXP : CRC_LEN_BASIC; // RULE15

	////////////////////////////////////////////////////////////////
	// Checksum engines over the two parameter streams.
	sts_crc u_ipar_crc (
		.clk_i        (clk_i),
		.rst_n_i      (rst_n_i),
		.byte_valid_i (par_valid_i & ~par_is_fpar_i),
		.byte_i       (par_byte_i),
		.last_i       (par_last_i),
		.expect_i     (fpar_i.device_params_checksum),
		.done_o       (devpar_done),
		.ok_o         (devpar_ok)
	);
	sts_crc u_fpar_crc (
		.clk_i        (clk_i),
		.rst_n_i      (rst_n_i),
		.byte_valid_i (par_valid_i & par_is_fpar_i),
		.byte_i       (par_byte_i),
		.last_i       (par_last_i),
		.expect_i     (fpar_i.fpar_checksum),
		.done_o       (fpar_done),
		.ok_o         (fpar_ok)
	);

	// Watchdog sleeps until a good telegram with good parameters ends start-up.
	sts_watchdog #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_wd (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.en_i        (state != S_START),
		.kick_i      (good_tlg),
		.period_ms_i (wd_period),
		.expired_o   (wd_fire)
	);

	////////////////////////////////////////////////////////////////
	// Passivation sequencer.
	always_comb begin
		next_state = state;
		case (state)
			// Start-up is passive until a good telegram with good parameters.
			S_START: begin
				if (good_tlg && param_ok) begin
					next_state = S_RUN;
				end
			end
			S_RUN: begin
				if (fault_evt) begin
					next_state = S_PASSIVE; // RULE5 RULE7
				end
			end
			// Leaving needs the operator, and no fault may still stand.
			S_PASSIVE: begin
				if (opack_rise && !fault_evt) begin
					next_state = S_RUN; // RULE9
				end
			end
			default: begin
				next_state = S_START;
			end
		endcase
	end

	// State register.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			state <= S_START;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////
	// Control byte capture; only checksum-good telegrams carry commands.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			safety_control_byte <= BYTE_RST;
			ctrl_prev           <= BYTE_RST;
		end else begin
			if (tlg_i.valid && tlg_i.crc_ok) begin
				safety_control_byte <= tlg_i.ctrl;
			end
			ctrl_prev <= safety_control_byte;
		end
	end

	////////////////////////////////////////////////////////////////
	// Parameter unlock handshake; the apply event beats the clear.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			param_write_ready_o <= 1'b0;
			param_set_applied   <= 1'b0;
		end else begin
			param_write_ready_o <= unlock_rise | (param_write_ready_o & ~unlock_fall); // RULE23
			param_set_applied <= (param_applied_i & param_write_ready_o)
				| (param_set_applied & ~unlock_fall); // RULE1 RULE23
		end
	end

	////////////////////////////////////////////////////////////////
	// Error flags. Each set wins over its clear in the same cycle.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			device_fault_q            <= 1'b0;
			channel_error_ack_needed  <= 1'b0;
			crc_err                   <= 1'b0;
			telegram_watchdog_expired <= 1'b0;
		end else begin
			device_fault_q <= device_fault_i; // RULE2
			channel_error_ack_needed <= (expanded_variant & channel_error_i)
				| (channel_error_ack_needed & ~chack_rise); // RULE3 RULE13
			crc_err <= crc_err_evt | (crc_err & ~reintegrate); // RULE4
			telegram_watchdog_expired <= wd_fire
				| (telegram_watchdog_expired & ~reintegrate); // RULE5
		end
	end

	////////////////////////////////////////////////////////////////
	// Virtual sequence counter and its reset report.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			seq_count_o           <= 16'h0;
			seq_counter_was_reset <= 1'b0;
		end else begin
			if (seqrst_rise) begin
				seq_count_o <= 16'h0; // RULE10
			end else if (good_tlg) begin
				seq_count_o <= seq_count_o + 16'h1;
			end
			seq_counter_was_reset <= seqrst_rise
				| (seq_counter_was_reset & ~seqrst_fall); // RULE8
		end
	end

	////////////////////////////////////////////////////////////////
	// Data path: zeros replace cyclic values while passive.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			data_o                   <= '0;
			substitute_values_active <= 1'b1;
		end else begin
			data_o <= passivated ? '0 : cyc_data_i; // RULE6 RULE12
			substitute_values_active <= passivated; // RULE6
		end
	end

	// Bit 1 meaning depends on the variant; bit 5 echoes the host toggle.
	assign safety_status_byte_o = {
		1'b0,                                        // RULE8
		seq_counter_was_reset,
		ctrl_prev[CT_TOGGLE],                        // RULE24
		substitute_values_active,
		telegram_watchdog_expired,
		crc_err,
		basic_variant ? device_fault_q : channel_error_ack_needed, // RULE2 RULE3
		param_set_applied
	};

	////////////////////////////////////////////////////////////////
	// Checks.
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_APPLIED: assert property (param_applied_i && param_write_ready_o
		|=> safety_status_byte_o[ST_APPLIED]) else $error("applied bit not set"); // RULE1
	AST_DEVFAULT: assert property (basic_variant && device_fault_i && $stable(fpar_i)
		|=> safety_status_byte_o[ST_FAULT]) else $error("fault bit missing"); // RULE2
	AST_CHERR: assert property (expanded_variant && channel_error_i
		|=> channel_error_ack_needed ##1 substitute_values_active)
		else $error("channel error not held"); // RULE3
	AST_CRCERR: assert property (crc_err_evt |=> safety_status_byte_o[ST_CRC])
		else $error("checksum error bit missing"); // RULE4
	AST_WDOG: assert property (wd_fire |=> safety_status_byte_o[ST_WD] && state != S_RUN)
		else $error("watchdog not passivating"); // RULE5
	AST_SUBST: assert property (passivated |=> data_o == '0
		&& safety_status_byte_o[ST_SUBST]) else $error("substitute values missing"); // RULE6
	AST_SEQRST: assert property (seqrst_rise |=> seq_count_o == 16'h0
		&& safety_status_byte_o[ST_SEQRST]) else $error("counter reset missed"); // RULE10
	// The echo is traced from the telegram itself, two edges after it is taken.
	AST_TOGGLE: assert property (tlg_i.valid && tlg_i.crc_ok |=> ##1 // RULE24
		safety_status_byte_o[ST_TOGGLE] == $past(tlg_i.ctrl[CT_TOGGLE], 2))
		else $error("toggle not mirrored");
	AST_PARAM: assert property (state == S_START && !param_ok |=> state == S_START)
		else $error("started with bad parameters"); // RULE19
	AST_REINT: assert property (state == S_PASSIVE && !opack_rise |=> state != S_RUN)
		else $error("left passive without ack"); // RULE9

	COV_RUN: cover property (state == S_START ##[1:20] state == S_RUN);
	COV_REINT: cover property (state == S_PASSIVE ##1 state == S_RUN);
	COV_CHACK: cover property (channel_error_ack_needed ##1 !channel_error_ack_needed);
endmodule : sts_trailer
`default_nettype wire

// ---- design/sts_watchdog.sv ----
// Purpose: Telegram watchdog counting milliseconds.
// Assumes: Kick comes from logic on the same clock.
// Notes:   A zero period selects the default time.
`default_nettype none
module sts_watchdog #(
	parameter int CYCLES_PER_MS = sts_pkg::CYC_PER_MS
) (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        en_i,
	input  wire logic        kick_i,
	input  wire logic [15:0] period_ms_i,
	output logic             expired_o
);
	import sts_pkg::*;
	logic [31:0] pre;    // Cycles within the current millisecond.
	logic [15:0] ms;     // Whole milliseconds since the last kick.
	wire         tick   = (pre == 32'(CYCLES_PER_MS - 1));
	wire  [15:0] limit  = (period_ms_i == 16'h0000) ? WD_TIME_DEF_MS : period_ms_i;

	////////////////////////////////////////////////////////////////
	// Counting restarts on every good telegram; expiry holds as a level.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i || kick_i || !en_i) begin
			pre       <= 32'h0;
			ms        <= 16'h0;
			expired_o <= 1'b0;
		end else begin
			pre <= tick ? 32'h0 : pre + 32'h1;
			if (tick && !expired_o) begin
				ms <= ms + 16'h1;
			end
			expired_o <= expired_o | (ms >= limit); // RULE5
		end
	end
endmodule : sts_watchdog
`default_nettype wire

// ---- shared/sts_pkg.sv ----
// Purpose: Shared constants and carriers for the safety trailer block.
// Assumes: 100 MHz processing clock.
// Notes:   Bit positions follow the status and control byte layout.
`default_nettype none
package sts_pkg;
	// Status byte bit positions.
	localparam int ST_APPLIED  = 0;
	localparam int ST_FAULT    = 1;
	localparam int ST_CRC      = 2;
	localparam int ST_WD       = 3;
	localparam int ST_SUBST    = 4;
	localparam int ST_TOGGLE   = 5;
	localparam int ST_SEQRST   = 6;
	// Control byte bit positions.
	localparam int CT_UNLOCK   = 0;
	localparam int CT_OPACK    = 1;
	localparam int CT_SEQRST   = 2;
	localparam int CT_WD2      = 3;
	localparam int CT_FORCE    = 4;
	localparam int CT_TOGGLE   = 5;
	localparam int CT_CHACK    = 6;
	// Reset value of the held control byte and its delayed copy.
	localparam logic [7:0] BYTE_RST = 8'h00;
	// Telegram checksum lengths in bytes.
	localparam logic [2:0] CRC_LEN_BASIC = 3'h3;
	localparam logic [2:0] CRC_LEN_EXP   = 3'h4;
	// Highest supported safety class code (none, SIL, SIL1..SIL3).
	localparam logic [2:0] SIL_MAX = 3'h4;
	// Address stored in the device.
	localparam logic [15:0] DEV_ADDR_DEF = 16'h0001;
	// Watchdog timing.
	localparam logic [15:0] WD_TIME_DEF_MS = 16'h007D;
	localparam int CLK_PERIOD_NS = 10;
	localparam int NS_PER_MS     = 1000000;
	localparam int CYC_PER_MS    = NS_PER_MS / CLK_PERIOD_NS;
	// Parameter checksum generator (neutral polynomial).
	localparam logic [31:0] CRC_POLY = 32'h04C11DB7;

	// One received telegram trailer.
	typedef struct packed {
		logic       valid;   // Telegram strobe.
		logic       crc_ok;  // Telegram checksum good.
		logic       current; // Sequence number is current.
		logic [7:0] ctrl;    // Control byte.
	} sts_tlg_t;

	// Fixed safety parameters from the host.
	typedef struct packed {
		logic        has_seed_passiv; // Selects the expanded variant.
		logic [15:0] dest_addr;
		logic [15:0] src_addr;
		logic [2:0]  requested_safety_class;
		logic [15:0] watchdog_period;
		logic [15:0] second_watchdog_period;
		logic        param_checksum_check_option;
		logic [31:0] device_params_checksum;
		logic [31:0] fpar_checksum;
	} sts_fpar_t;
endpackage : sts_pkg
`default_nettype wire

// ---- verif/safety_trailer_status_control_tb_top.sv ----
// Purpose: Self-checking bench for the safe status and control handling.
// Assumes: The host model keeps the telegrams flowing unless a test stops them.
// Notes:   One millisecond is shortened to 10 cycles to keep the run short.
`default_nettype none
module safety_trailer_status_control_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import sts_pkg::*;

	localparam int GAP    = 8;           // Telegram spacing in cycles.
	localparam int SETTLE = 2 * GAP + 3; // Two telegrams plus the capture delay.

	logic        clk = 1'h0;
	logic        rst_n = 1'h0;
	logic        run = 1'h0;
	logic        crc_bad = 1'h0;
	logic        expanded_sel = 1'h0;
	logic [7:0]  ctrl = 8'h0;
	logic        applied = 1'h0;
	logic        device_fault = 1'h0;
	logic        channel_error = 1'h0;
	logic        window_exceeded = 1'h0;
	logic        internal_fault = 1'h0;
	logic [31:0] cyc_data = 32'hC3A55A3C;
	sts_tlg_t    tlg;
	sts_fpar_t   fpar;
	logic        par_valid, par_last, par_is_fpar;
	logic [7:0]  par_byte, status;
	logic [31:0] data;
	logic        ready, expanded_seen;
	logic [15:0] seq_count;
	logic [2:0]  crc_len;
	int          n_fail = 0;
	int          samples_checked = 0;

	always #5 clk = ~clk;

	sts_host_model #(.TLG_GAP(GAP)) sts_host_model_inst (.clk_i(clk), .run_i(run),
		.crc_bad_i(crc_bad), .expanded_i(expanded_sel), .ctrl_i(ctrl), .tlg_o(tlg),
		.fpar_o(fpar),
		.par_valid_o(par_valid), .par_byte_o(par_byte), .par_last_o(par_last),
		.par_is_fpar_o(par_is_fpar));

	sts_trailer #(.CYCLES_PER_MS(10)) sts_trailer_inst (.clk_i(clk), .rst_n_i(rst_n),
		.tlg_i(tlg), .fpar_i(fpar), .par_valid_i(par_valid), .par_byte_i(par_byte),
		.par_last_i(par_last), .par_is_fpar_i(par_is_fpar), .param_applied_i(applied),
		.device_fault_i(device_fault), .channel_error_i(channel_error),
		.window_exceeded_i(window_exceeded), .internal_tlg_fault_i(internal_fault),
		.cyc_data_i(cyc_data), .data_o(data), .safety_status_byte_o(status),
		.param_write_ready_o(ready), .expanded_variant_o(expanded_seen),
		.crc_len_o(crc_len), .seq_count_o(seq_count));

	////////////////////////////////////////////////////////////////////////////////
	// Single comparison point; the four-state compare keeps unknowns from passing.
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// Ends the run with the verdict.
	task automatic tally_and_finish();
		if (n_fail == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : tally_and_finish

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc

	// Control changes only take effect through telegrams, so wait for two.
	// Host-side inputs change by non-blocking assignment, so the host model,
	// which also wakes on the falling edge, always sees them one edge later.
	task automatic set_ctrl(input logic [7:0] v);
		ctrl <= v;
		cyc(SETTLE);
	endtask : set_ctrl

	////////////////////////////////////////////////////////////////////////////////
	// Reset leaves the device passive with the variant fixed by the parameters.
	task automatic do_reset(input logic expanded);
		run <= 1'h0;
		expanded_sel <= expanded;
		rst_n = 1'h0;
		cyc(6);
		rst_n = 1'h1;
		check("reset_status", 32'(status), 32'h10);
		check("reset_data", data, 32'h0);
		check("variant", 32'(expanded_seen), 32'(expanded));
		check("crc_len", 32'(crc_len), expanded ? 32'h4 : 32'h3);
	endtask : do_reset

	// Both checksums must match before the first good telegram starts the device.
	task automatic start_up();
		sts_host_model_inst.send_stream(1'h0);
		sts_host_model_inst.send_stream(1'h1);
		run <= 1'h1;
		cyc(SETTLE);
		check("start_status", 32'(status), 32'h0);
		check("start_data", data, cyc_data);
	endtask : start_up

	// A rising operator acknowledge leaves the passive state and clears the flags.
	task automatic reintegrate();
		set_ctrl(8'h02);
		check("reint_status", 32'(status), 32'h0);
		check("reint_data", data, cyc_data);
		set_ctrl(8'h00);
	endtask : reintegrate

	task automatic t_bits();
		set_ctrl(8'h20);
		check("toggle", 32'(status), 32'h20);
		set_ctrl(8'h10);
		check("force_status", 32'(status), 32'h10);
		check("force_data", data, 32'h0);
		set_ctrl(8'h04);
		check("seq_reset", 32'(status), 32'h40);
		// At most two telegrams follow the restart before this look.
		check("seq_count", 32'(seq_count < 16'h3), 32'h1);
		set_ctrl(8'h01);
		check("unlock", 32'(ready), 32'h1);
		applied = 1'h1;
		cyc(1);
		applied = 1'h0;
		cyc(2);
		check("applied", 32'(status), 32'h01);
		set_ctrl(8'h00);
		check("applied_clear", 32'(status), 32'h00);
	endtask : t_bits

	// Bad checksums, the device, window and internal faults and a silent host each passivate.
	task automatic t_faults();
		crc_bad <= 1'h1;
		cyc(GAP + 3);
		check("crc_status", 32'(status), 32'h14);
		crc_bad <= 1'h0;
		reintegrate();
		for (int i = 0; i < 3; i++) begin
			{internal_fault, window_exceeded, device_fault} = 3'h1 << i;
			cyc(3);
			check("fault_status", 32'(status), (i == 0) ? 32'h12 : 32'h10);
			check("fault_data", data, 32'h0);
			{internal_fault, window_exceeded, device_fault} = 3'h0;
			cyc(3);
			reintegrate();
		end
		run <= 1'h0;
		cyc(60);
		check("wd_status", 32'(status), 32'h18);
		run <= 1'h1;
		reintegrate();
	endtask : t_faults

	// Expanded only: channel error with acknowledge, then the shorter watchdog.
	task automatic t_expanded();
		channel_error = 1'h1;
		cyc(3);
		channel_error = 1'h0;
		cyc(3);
		check("chan_err", 32'(status[ST_FAULT]), 32'h1);
		set_ctrl(8'h40);
		check("chan_ack", 32'(status[ST_FAULT]), 32'h0);
		set_ctrl(8'h08);
		run <= 1'h0;
		cyc(40);
		check("wd2", 32'(status[ST_WD]), 32'h1);
	endtask : t_expanded

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		do_reset(1'h0);
		start_up();
		t_bits();
		t_faults();
		do_reset(1'h1);
		start_up();
		t_expanded();
		tally_and_finish();
	end

	// The whole sequence needs well under 2000 cycles; this cuts a hang short.
	initial begin
		#200000;
		n_fail++;
		tally_and_finish();
	end
endmodule : safety_trailer_status_control_tb_top
`default_nettype wire

// ---- verif/sts_host_model.sv ----
// Purpose: Host model that sends cyclic telegrams, parameter streams and fixed parameters.
// Assumes: Every output changes on the falling edge of clk_i only.
// Notes:   The control byte is sent again every TLG_GAP cycles while run_i is high.
`default_nettype none
module sts_host_model #(
	parameter int TLG_GAP = 8
) (
	input  wire logic              clk_i,
	input  wire logic              run_i,
	input  wire logic              crc_bad_i,
	input  wire logic              expanded_i,
	input  wire logic [7:0]        ctrl_i,
	output var sts_pkg::sts_tlg_t  tlg_o,
	output var sts_pkg::sts_fpar_t fpar_o,
	output var logic               par_valid_o,
	output var logic [7:0]         par_byte_o,
	output var logic               par_last_o,
	output var logic               par_is_fpar_o
);
	timeunit 1ns;
	timeprecision 1ns;
	import sts_pkg::*;

	int gap_cnt = 0; // Cycles since the last telegram slot.

	////////////////////////////////////////////////////////////////////////////////
	// The checksum is shifted in msb first from zero, with no final inversion.
	function automatic logic [31:0] crc_of(input logic [7:0] base);
		logic [31:0] c;
		logic [7:0]  d;
		c = 32'h0;
		for (int k = 0; k < 4; k++) begin
			d = base + 8'(k);
			for (int b = 7; b >= 0; b--) begin
				c = {c[30:0], 1'h0} ^ ((c[31] ^ d[b]) ? CRC_POLY : 32'h0);
			end
		end
		return c;
	endfunction : crc_of

	// The parameters are fixed levels; the source differs from the destination.
	assign fpar_o = '{has_seed_passiv: expanded_i,
		dest_addr: DEV_ADDR_DEF, src_addr: 16'h2,
		requested_safety_class: 3'h3,
		watchdog_period: 16'h5, second_watchdog_period: 16'h3,
		param_checksum_check_option: 1'h1,
		device_params_checksum: crc_of(8'h10),
		fpar_checksum: crc_of(8'h80)};

	// All outputs but fpar_o are quiet at time zero.
	initial begin
		tlg_o = '0;
		{par_valid_o, par_last_o, par_is_fpar_o, par_byte_o} = '0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Telegram slots; in the expanded variant the loop check bit is always high.
	always @(negedge clk_i) begin
		gap_cnt <= (gap_cnt == TLG_GAP - 1) ? 0 : gap_cnt + 1;
		tlg_o.valid <= run_i && (gap_cnt == 0);
		tlg_o.crc_ok <= !crc_bad_i;
		tlg_o.current <= 1'h1;
		tlg_o.ctrl <= expanded_i ? (ctrl_i | 8'h80) : (ctrl_i & 8'h37);
	end

	// Sends one stream of four bytes; the bus is scrambled once it is released.
	task automatic send_stream(input logic is_fpar);
		for (int k = 0; k < 4; k++) begin
			@(negedge clk_i);
			par_valid_o <= 1'h1;
			par_is_fpar_o <= is_fpar;
			par_byte_o <= (is_fpar ? 8'h80 : 8'h10) + 8'(k);
			par_last_o <= (k == 3);
		end
		@(negedge clk_i);
		par_valid_o <= 1'h0;
		par_last_o <= 1'h0;
		par_byte_o <= ~par_byte_o;
	endtask : send_stream
endmodule : sts_host_model
`default_nettype wire
